//--- pbaf_change_detect.v
/*
  pin-change detector: compares the gated digital inputs with the previous
  sample and raises a one-cycle pulse per group for any armed pin that moved.
  assumes inputs are synchronous to mclk.
*/
`timescale 1ns/1ps
`include "pbaf_regs.vh"
module pbaf_change_detect #(
  parameter WIDTH = 8,
  parameter SPLIT = 4
) (
  mclk,
  resetn,
  din,
  armed,
  change_high,
  change_low
);
  input  wire             mclk;
  input  wire             resetn;
  input  wire [WIDTH-1:0] din;
  input  wire [WIDTH-1:0] armed;
  output reg              change_high;
  output reg              change_low;

  reg  [WIDTH-1:0] prev_reg;
  reg              primed_reg;
  wire [WIDTH-1:0] moved;

  // masked pins still update the history so unmasking cannot fire stale edges
  assign moved = (din ^ prev_reg) & armed;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prev_reg    <= {WIDTH{1'b0}};
      primed_reg  <= 1'b0;
      change_high <= 1'b0;
      change_low  <= 1'b0;
    end else begin
      // first edge only loads history, so a pin idling high gives no false pulse
      prev_reg    <= din;
      primed_reg  <= 1'b1;
      change_high <= primed_reg & (|moved[WIDTH-1:SPLIT]);
      change_low  <= primed_reg & (|moved[SPLIT-1:0]);
    end
  end
endmodule

//--- pbaf_checker.sv
/* port checker for pbaf_port_b_override, bound into every instance.
   assumes outputs register the inputs of the previous mclk edge. */
`timescale 1ns/1ps
`include "pbaf_regs.vh"
module pbaf_chk (
  input wire       mclk,
  input wire       resetn,
  input wire [7:0] pin_in,
  input wire [7:0] port_out_reg,
  input wire [7:0] direction_reg,
  input wire       reset_pin_disable_fuse,
  input wire       global_irq_en,
  input wire       pin_change_group_low,
  input wire [7:0] general_irq_mask_reg,
  input wire [7:0] counter0_control_reg,
  input wire [1:0] clock_source,
  input wire       timer1_compare_b_en,
  input wire       timer1_compare_b_wave,
  input wire       spi_program_en,
  input wire [1:0] ser_wire_mode,
  input wire       ser_start_detect,
  input wire       ser_shift_msb,
  input wire [7:0] pad_drive_en,
  input wire [7:0] pad_drive_val,
  input wire [7:0] pad_pullup_en,
  input wire [7:0] digital_in,
  input wire       ext_reset_n,
  input wire       external_irq_zero,
  input wire       counter0_ext_clock_in,
  input wire       pin_change_irq_low
);
  // $past needs a few edges of fresh history after every reset release
  logic [1:0] up_cnt_reg;
  wire        up = up_cnt_reg == 2'h3;
  always @(posedge mclk or negedge resetn)
    if (!resetn) up_cnt_reg <= 2'h0;
    else if (!up) up_cnt_reg <= up_cnt_reg + 2'h1;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_lo3_armed;
    global_irq_en && pin_change_group_low && !timer1_compare_b_en;
  endsequence
  sequence s_lo3_moved;
    s_lo3_armed ##1 s_lo3_armed ##0 $changed(pin_in[3]);
  endsequence
  sequence s_two_wire;
    !spi_program_en && ser_wire_mode == `PBAF_SER_TWO;
  endsequence
  property p_reset;
    up |-> ext_reset_n == ($past(reset_pin_disable_fuse) ? $past(pin_in[7]) : 1'b1);
  endproperty
  property p_reset_pad;
    up && $past(reset_pin_disable_fuse) |-> pad_pullup_en[7] && !pad_drive_en[7] && !digital_in[7];
  endproperty
  property p_irq0;
    up |-> external_irq_zero == ($past(general_irq_mask_reg[6]) && $past(pin_in[6]));
  endproperty
  property p_cnt_clk;
    up |-> counter0_ext_clock_in == (&$past(counter0_control_reg[2:1]) && $past(pin_in[6]));
  endproperty
  property p_xtal;
    up && $past(clock_source) == `PBAF_CLK_XTAL |-> !(|pad_drive_en[5:4]) && !(|pad_pullup_en[5:4]);
  endproperty
  property p_cmp_b;
    up && $past(timer1_compare_b_en) |-> pad_drive_en[3] == $past(direction_reg[3])
      && (!pad_drive_en[3] || pad_drive_val[3] == $past(timer1_compare_b_wave));
  endproperty
  property p_scl;
    up ##0 s_two_wire ##0 direction_reg[2] |=> !pad_pullup_en[2] && !(pad_drive_en[2]
      && pad_drive_val[2]) && pad_drive_en[2] == $past(!port_out_reg[2] || ser_start_detect);
  endproperty
  property p_sda;
    up ##0 s_two_wire ##0 direction_reg[0] |=> !(pad_drive_en[0] && pad_drive_val[0])
      && pad_drive_en[0] == $past(!port_out_reg[0] || !ser_shift_msb);
  endproperty
  property p_change_low;
    up ##0 s_lo3_moved |=> pin_change_irq_low;
  endproperty
  a_reset: assert property (p_reset) else $error("reset request level wrong");
  a_reset_pad: assert property (p_reset_pad) else $error("reset pin pad wrong");
  a_irq0: assert property (p_irq0) else $error("irq zero input wrong");
  a_cnt_clk: assert property (p_cnt_clk) else $error("counter clock input wrong");
  a_xtal: assert property (p_xtal) else $error("oscillator pins not claimed");
  a_cmp_b: assert property (p_cmp_b) else $error("compare b pin wrong");
  a_scl: assert property (p_scl) else $error("two-wire clock pin wrong");
  a_sda: assert property (p_sda) else $error("two-wire data pin wrong");
  a_change_low: assert property (p_change_low) else $error("change pulse missing");
endmodule
bind pbaf_port_b_override pbaf_chk u_chk (.*);

//--- pbaf_pin_cell.v
/*
  one port pin's override merge: combines the port register bits with
  override enables and values into pull-up, driver enable, output value
  and digital input enable. purely combinational; caller registers outputs.
*/
`timescale 1ns/1ps
module pbaf_pin_cell (
  port_bit,
  dir_bit,
  sleep_mode,
  pu_ovr_en,
  pu_ovr_val,
  dir_ovr_en,
  dir_ovr_val,
  val_ovr_en,
  val_ovr_val,
  die_ovr_en,
  die_ovr_val,
  pullup_en,
  drive_en,
  drive_val,
  din_en
);
  input  wire port_bit;
  input  wire dir_bit;
  input  wire sleep_mode;
  input  wire pu_ovr_en;
  input  wire pu_ovr_val;
  input  wire dir_ovr_en;
  input  wire dir_ovr_val;
  input  wire val_ovr_en;
  input  wire val_ovr_val;
  input  wire die_ovr_en;
  input  wire die_ovr_val;
  output wire pullup_en;
  output wire drive_en;
  output wire drive_val;
  output wire din_en;

  // the pull-up follows the port bit only while the pin is an input
  assign pullup_en = pu_ovr_en  ? pu_ovr_val  : (port_bit & ~dir_bit);
  assign drive_en  = dir_ovr_en ? dir_ovr_val : dir_bit;
  assign drive_val = val_ovr_en ? val_ovr_val : port_bit;
  // digital inputs are cut in sleep to save power unless kept alive
  assign din_en    = die_ovr_en ? die_ovr_val : ~sleep_mode;
endmodule

//--- pbaf_pin_model.sv
/* pads and outside world of port b: design driver wins, then an outside
   driver, then the pull-up; a floating pin toggles every cycle. */
`timescale 1ns/1ps
module pbaf_pin_model (
  input  wire       mclk,
  input  wire [7:0] drive_en,
  input  wire [7:0] drive_val,
  input  wire [7:0] pullup_en,
  input  wire [7:0] ext_drive,
  input  wire [7:0] ext_val,
  output wire [7:0] level
);
  // a floating pad must not settle to a convenient value
  logic [7:0] float_reg = 8'h00;
  always @(posedge mclk) float_reg <= ~level;
  assign level = (drive_en & drive_val) | (~drive_en & ext_drive & ext_val)
    | (~drive_en & ~ext_drive & (pullup_en | float_reg));
endmodule

//--- pbaf_port_b_override.v
/*
  port b alternate-function override for a small 8-bit controller.
  steers each pin between plain i/o and reset, external irq, counter clock,
  oscillator, compare/pwm and serial-unit functions, gates pin-change irqs
  and keeps digital inputs alive in sleep. all outputs are registered.
  assumes every input is synchronous to mclk; pads resolve from drive_en.
*/
// Functional notes
// - top pin is reset while fuse reads one
// - reset pin: pull-up on, driver, input off
// - reset use masks top pin change irq
// - unmasked enabled change irq keeps input awake
// - change irq needs global, group enable, unmasked
// - sixth pin feeds external irq zero
// - both upper clock bits select counter0 pin
// - irq zero or counter clock masks change
// - oscillator output pin free for rc/ext/pll
// - oscillator input pin free for rc/pll
// - crystal masks both pins' change irq, ext clock the input's
// - compare b reaches pin three if output
// - compare b output masks its change irq
// - programming forces input; three-wire uses direction
// - two-wire clock low on port zero/start
// - two-wire mode removes clock pin pull-up
// - inverted pwm b needs serial off, output
// - inverted b or serial clock masks change
// - three-wire data out replaces port value
// - port bit still drives data pin pull-up
// - compare a needs output, no programming/serial
// - compare a or data out masks change
// - two-wire data low on port or shift zero
`timescale 1ns/1ps
`include "pbaf_regs.vh"
module pbaf_port_b_override #(
  parameter WIDTH = 8
) (
  mclk,
  resetn,
  pin_in,
  port_out_reg,
  direction_reg,
  sleep_mode,
  reset_pin_disable_fuse,
  global_irq_en,
  pin_change_group_high,
  pin_change_group_low,
  general_irq_mask_reg,
  counter0_control_reg,
  clock_source,
  timer1_compare_a_en,
  timer1_compare_a_wave,
  timer1_compare_b_en,
  timer1_compare_b_wave,
  spi_program_en,
  ser_wire_mode,
  ser_start_detect,
  ser_data_out,
  ser_clock_out,
  ser_shift_msb,
  pad_drive_en,
  pad_drive_val,
  pad_pullup_en,
  digital_in,
  ext_reset_n,
  external_irq_zero,
  counter0_ext_clock_in,
  oscillator_input_pin,
  pin_change_irq_high,
  pin_change_irq_low
);
  input  wire             mclk;
  input  wire             resetn;
  input  wire [WIDTH-1:0] pin_in;
  input  wire [WIDTH-1:0] port_out_reg;
  input  wire [WIDTH-1:0] direction_reg;
  input  wire             sleep_mode;
  input  wire             reset_pin_disable_fuse;
  input  wire             global_irq_en;
  input  wire             pin_change_group_high;
  input  wire             pin_change_group_low;
  input  wire [7:0]       general_irq_mask_reg;
  input  wire [7:0]       counter0_control_reg;
  input  wire [1:0]       clock_source;
  input  wire             timer1_compare_a_en;
  input  wire             timer1_compare_a_wave;
  input  wire             timer1_compare_b_en;
  input  wire             timer1_compare_b_wave;
  input  wire             spi_program_en;
  input  wire [1:0]       ser_wire_mode;
  input  wire             ser_start_detect;
  input  wire             ser_data_out;
  input  wire             ser_clock_out;
  input  wire             ser_shift_msb;
  output reg  [WIDTH-1:0] pad_drive_en;
  output reg  [WIDTH-1:0] pad_drive_val;
  output reg  [WIDTH-1:0] pad_pullup_en;
  output reg  [WIDTH-1:0] digital_in;
  output reg              ext_reset_n;
  output reg              external_irq_zero;
  output reg              counter0_ext_clock_in;
  output reg              oscillator_input_pin;
  output wire             pin_change_irq_high;
  output wire             pin_change_irq_low;

  // override vectors, one bit per pin
  reg  [WIDTH-1:0] pu_oe;
  reg  [WIDTH-1:0] pu_ov;
  reg  [WIDTH-1:0] dd_oe;
  reg  [WIDTH-1:0] dd_ov;
  reg  [WIDTH-1:0] pv_oe;
  reg  [WIDTH-1:0] pv_ov;
  reg  [WIDTH-1:0] die_oe;
  reg  [WIDTH-1:0] die_ov;
  reg  [WIDTH-1:0] pc_mask;
  wire [WIDTH-1:0] pc_group;
  wire [WIDTH-1:0] pc_armed;
  wire [WIDTH-1:0] cell_pullup;
  wire [WIDTH-1:0] cell_drive_en;
  wire [WIDTH-1:0] cell_drive_val;
  wire [WIDTH-1:0] cell_din_en;
  wire [WIDTH-1:0] din_gated;

  function ser_is;
    input [1:0] mode;
    input [1:0] want;
    begin
      ser_is = (mode == want);
    end
  endfunction

  wire reset_pin_used = reset_pin_disable_fuse;
  wire irq0_en        = general_irq_mask_reg[`PBAF_IRQ0_EN_BIT];
  wire irq0_level_on  = irq0_en & global_irq_en;
  wire cnt0_ext_clock = counter0_control_reg[`PBAF_CS_HI] &
                        counter0_control_reg[`PBAF_CS_MID];
  wire xout_io        = (clock_source == `PBAF_CLK_RC)  |
                        (clock_source == `PBAF_CLK_EXT) |
                        (clock_source == `PBAF_CLK_PLL);
  wire xin_io         = (clock_source == `PBAF_CLK_RC)  |
                        (clock_source == `PBAF_CLK_PLL);
  wire xin_ext_clock  = (clock_source == `PBAF_CLK_EXT);
  wire ser_three      = ser_is(ser_wire_mode, `PBAF_SER_THREE);
  wire ser_two        = ser_is(ser_wire_mode, `PBAF_SER_TWO);
  wire ser_on         = ser_three | ser_two;
  wire pwm_b_inv_on   = timer1_compare_b_en & ~ser_on & ~spi_program_en;
  wire pwm_a_free     = ~ser_on & ~spi_program_en;
  wire pwm_a_on       = timer1_compare_a_en & pwm_a_free;

  // group membership: upper four pins are the high group
  assign pc_group = {{(WIDTH-4){pin_change_group_high}}, {4{pin_change_group_low}}};
  assign pc_armed = {WIDTH{global_irq_en}} & pc_group & ~pc_mask;

  always @* begin
    pu_oe   = {WIDTH{1'b0}};
    pu_ov   = {WIDTH{1'b0}};
    dd_oe   = {WIDTH{1'b0}};
    dd_ov   = {WIDTH{1'b0}};
    pv_oe   = {WIDTH{1'b0}};
    pv_ov   = {WIDTH{1'b0}};
    die_oe  = {WIDTH{1'b0}};
    die_ov  = {WIDTH{1'b0}};
    pc_mask = {WIDTH{1'b0}};

    // top pin as reset: pull-up on, driver off, input cut
    if (reset_pin_used) begin
      pu_oe[`PBAF_PIN_RESET]  = 1'b1;
      pu_ov[`PBAF_PIN_RESET]  = 1'b1;
      dd_oe[`PBAF_PIN_RESET]  = 1'b1;
      die_oe[`PBAF_PIN_RESET] = 1'b1;
      pc_mask[`PBAF_PIN_RESET] = 1'b1;
    end

    // sixth pin: irq zero and counter clock keep their input awake
    pc_mask[`PBAF_PIN_IRQ0] = irq0_level_on | cnt0_ext_clock;
    if (irq0_en | cnt0_ext_clock) begin
      die_oe[`PBAF_PIN_IRQ0] = 1'b1;
      die_ov[`PBAF_PIN_IRQ0] = 1'b1;
    end

    // oscillator pins: claimed pins lose pull-up and driver
    if (!xout_io) begin
      pu_oe[`PBAF_PIN_XOUT]   = 1'b1;
      dd_oe[`PBAF_PIN_XOUT]   = 1'b1;
      die_oe[`PBAF_PIN_XOUT]  = 1'b1;
      pc_mask[`PBAF_PIN_XOUT] = 1'b1;
    end
    if (!xin_io) begin
      pu_oe[`PBAF_PIN_XIN]   = 1'b1;
      dd_oe[`PBAF_PIN_XIN]   = 1'b1;
      die_oe[`PBAF_PIN_XIN]  = 1'b1;
      pc_mask[`PBAF_PIN_XIN] = 1'b1;
    end
    // an external clock still needs the input buffer, even in sleep
    if (xin_ext_clock) begin
      die_ov[`PBAF_PIN_XIN] = 1'b1;
    end

    // pin three: compare b drives only when the direction bit is set
    if (timer1_compare_b_en) begin
      pv_oe[`PBAF_PIN_OCB]   = 1'b1;
      pv_ov[`PBAF_PIN_OCB]   = timer1_compare_b_wave;
      pc_mask[`PBAF_PIN_OCB] = 1'b1;
    end

    // pin two: serial clock or inverted pwm b
    if (spi_program_en) begin
      dd_oe[`PBAF_PIN_SCK] = 1'b1;
      dd_ov[`PBAF_PIN_SCK] = 1'b0;
    end else if (ser_three) begin
      // direction bit picks master (drive) or slave (listen)
      pv_oe[`PBAF_PIN_SCK] = 1'b1;
      pv_ov[`PBAF_PIN_SCK] = ser_clock_out;
    end else if (ser_two) begin
      // open drain: only ever drives low, released otherwise
      pu_oe[`PBAF_PIN_SCK] = 1'b1;
      dd_oe[`PBAF_PIN_SCK] = 1'b1;
      dd_ov[`PBAF_PIN_SCK] = direction_reg[`PBAF_PIN_SCK] &
                             (~port_out_reg[`PBAF_PIN_SCK] | ser_start_detect);
      pv_oe[`PBAF_PIN_SCK] = 1'b1;
    end else if (pwm_b_inv_on) begin
      pv_oe[`PBAF_PIN_SCK] = 1'b1;
      pv_ov[`PBAF_PIN_SCK] = ~timer1_compare_b_wave;
    end
    pc_mask[`PBAF_PIN_SCK] = pwm_b_inv_on | ser_on;

    // pin one: serial data out or compare a
    if (spi_program_en) begin
      pv_oe[`PBAF_PIN_DO] = 1'b0;
    end else if (ser_three) begin
      // pull-up left to the port bit through the cell
      pv_oe[`PBAF_PIN_DO] = 1'b1;
      pv_ov[`PBAF_PIN_DO] = ser_data_out;
    end else if (pwm_a_on) begin
      pv_oe[`PBAF_PIN_DO] = 1'b1;
      pv_ov[`PBAF_PIN_DO] = timer1_compare_a_wave;
    end
    pc_mask[`PBAF_PIN_DO] = pwm_a_on | ser_three;

    // lowest pin: two-wire data, or inverted compare a
    if (ser_two && !spi_program_en) begin
      pu_oe[`PBAF_PIN_DIN] = 1'b1;
      dd_oe[`PBAF_PIN_DIN] = 1'b1;
      dd_ov[`PBAF_PIN_DIN] = direction_reg[`PBAF_PIN_DIN] &
                             (~port_out_reg[`PBAF_PIN_DIN] | ~ser_shift_msb);
      pv_oe[`PBAF_PIN_DIN] = 1'b1;
    end else if (pwm_a_on) begin
      pv_oe[`PBAF_PIN_DIN] = 1'b1;
      pv_ov[`PBAF_PIN_DIN] = ~timer1_compare_a_wave;
    end
    pc_mask[`PBAF_PIN_DIN] = pwm_a_on | ser_on;

    // unmasked, enabled change irq keeps each remaining input awake
    die_oe = die_oe | pc_armed;
    die_ov = die_ov | pc_armed;
    // reset pin input stays cut whatever the change enables say
    if (reset_pin_used) begin
      die_ov[`PBAF_PIN_RESET] = 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_pin
      pbaf_pin_cell u_cell (
        .port_bit    (port_out_reg[gi]),
        .dir_bit     (direction_reg[gi]),
        .sleep_mode  (sleep_mode),
        .pu_ovr_en   (pu_oe[gi]),
        .pu_ovr_val  (pu_ov[gi]),
        .dir_ovr_en  (dd_oe[gi]),
        .dir_ovr_val (dd_ov[gi]),
        .val_ovr_en  (pv_oe[gi]),
        .val_ovr_val (pv_ov[gi]),
        .die_ovr_en  (die_oe[gi]),
        .die_ovr_val (die_ov[gi]),
        .pullup_en   (cell_pullup[gi]),
        .drive_en    (cell_drive_en[gi]),
        .drive_val   (cell_drive_val[gi]),
        .din_en      (cell_din_en[gi])
      );
    end
  endgenerate

  assign din_gated = pin_in & cell_din_en;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pad_drive_en          <= `PBAF_RST_BYTE;
      pad_drive_val         <= `PBAF_RST_BYTE;
      pad_pullup_en         <= `PBAF_RST_BYTE;
      digital_in            <= `PBAF_RST_BYTE;
      ext_reset_n           <= `PBAF_RST_HIGH;
      external_irq_zero     <= 1'b0;
      counter0_ext_clock_in <= 1'b0;
      oscillator_input_pin  <= 1'b0;
    end else begin
      pad_drive_en          <= cell_drive_en;
      pad_drive_val         <= cell_drive_val;
      pad_pullup_en         <= cell_pullup;
      digital_in            <= din_gated;
      // reset is an analog path, so it bypasses the cut digital input
      ext_reset_n           <= reset_pin_used ? pin_in[`PBAF_PIN_RESET] : 1'b1;
      external_irq_zero     <= irq0_en & din_gated[`PBAF_PIN_IRQ0];
      counter0_ext_clock_in <= cnt0_ext_clock & din_gated[`PBAF_PIN_IRQ0];
      oscillator_input_pin  <= xin_ext_clock & pin_in[`PBAF_PIN_XIN];
    end
  end

  // fires on output pins too: it watches the pad, not the port register
  pbaf_change_detect #(
    .WIDTH (WIDTH),
    .SPLIT (4)
  ) u_change (
    .mclk        (mclk),
    .resetn      (resetn),
    .din         (din_gated),
    .armed       (pc_armed),
    .change_high (pin_change_irq_high),
    .change_low  (pin_change_irq_low)
  );
endmodule

//--- pbaf_regs.vh
/*
  constants for the port b alternate-function override block: clock source
  codes, serial unit mode codes and bit positions of the control inputs.
  assumes it is included by bare name from the pbaf design files.
*/
`ifndef PBAF_REGS_VH
`define PBAF_REGS_VH

// chip clock source selection, decoded from the clock fuses outside
`define PBAF_CLK_RC        2'h0
`define PBAF_CLK_EXT       2'h1
`define PBAF_CLK_PLL       2'h2
`define PBAF_CLK_XTAL      2'h3

// universal serial unit wire mode
`define PBAF_SER_OFF       2'h0
`define PBAF_SER_THREE     2'h1
`define PBAF_SER_TWO       2'h2

// bit of the general irq mask register that enables external irq zero
`define PBAF_IRQ0_EN_BIT   6
// bits of the counter0 control register selecting the external clock
`define PBAF_CS_HI         2
`define PBAF_CS_MID        1

// pin indices
`define PBAF_PIN_RESET     7
`define PBAF_PIN_IRQ0      6
`define PBAF_PIN_XOUT      5
`define PBAF_PIN_XIN       4
`define PBAF_PIN_OCB       3
`define PBAF_PIN_SCK       2
`define PBAF_PIN_DO        1
`define PBAF_PIN_DIN       0

// reset values of the registered outputs
`define PBAF_RST_BYTE      8'h00
`define PBAF_RST_HIGH      1'h1

`endif

//--- tb.sv
/* self-checking bench for pbaf_port_b_override with the pin model.
   assumes outputs follow inputs one mclk edge later. */
`timescale 1ns/1ps
`include "pbaf_regs.vh"
module tb;
  logic        mclk, resetn, sleep_mode, reset_pin_disable_fuse, global_irq_en;
  logic        pin_change_group_high, pin_change_group_low, spi_program_en;
  logic        ser_start_detect, ser_data_out, ser_clock_out, ser_shift_msb;
  logic        timer1_compare_a_en, timer1_compare_a_wave;
  logic        timer1_compare_b_en, timer1_compare_b_wave;
  logic [7:0]  port_out_reg, direction_reg, general_irq_mask_reg, counter0_control_reg;
  logic [7:0]  ext_drive, ext_val, p;
  logic [1:0]  clock_source, ser_wire_mode;
  wire  [7:0]  pin_in, pad_drive_en, pad_drive_val, pad_pullup_en, digital_in;
  wire         ext_reset_n, external_irq_zero, counter0_ext_clock_in, oscillator_input_pin;
  wire         pin_change_irq_high, pin_change_irq_low;
  int          failures = 0;
  int          checks = 0;
  logic [7:0]  hi, lo;
  logic [31:0] seed = 32'h0000_68b6;
  pbaf_port_b_override uut (.*);
  pbaf_pin_model u_pins (.mclk(mclk), .drive_en(pad_drive_en), .drive_val(pad_drive_val),
    .pullup_en(pad_pullup_en), .ext_drive(ext_drive), .ext_val(ext_val), .level(pin_in));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, e, m);
    checks++;
    if ((g & m) !== (e & m)) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g & m, e & m);
    end
  endtask
  task automatic chk1(input logic g, e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %b expected %b", $time, g, e);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // all quiet, every pin held by an outside driver, change irqs armed
  task automatic quiet;
    {sleep_mode, reset_pin_disable_fuse, spi_program_en, ser_start_detect, ser_data_out,
     ser_clock_out, ser_shift_msb, timer1_compare_a_en, timer1_compare_a_wave,
     timer1_compare_b_en, timer1_compare_b_wave} <= '0;
    {port_out_reg, direction_reg, general_irq_mask_reg, counter0_control_reg, ext_val,
     clock_source, ser_wire_mode} <= '0;
    {global_irq_en, pin_change_group_high, pin_change_group_low, ext_drive} <= {3'h7, 8'hff};
  endtask
  task automatic rnd_inputs;
    logic [31:0] a, b;
    seed = xs(seed);
    a = seed;
    seed = xs(seed);
    b = seed;
    {port_out_reg, direction_reg, ext_val, ext_drive} <= a;
    {general_irq_mask_reg, counter0_control_reg, clock_source, ser_wire_mode} <= b[19:0];
    {reset_pin_disable_fuse, global_irq_en, pin_change_group_high, pin_change_group_low,
     spi_program_en, ser_start_detect, ser_data_out, ser_shift_msb} <= b[27:20];
    {timer1_compare_a_en, timer1_compare_a_wave, timer1_compare_b_en,
     timer1_compare_b_wave} <= b[31:28];
    {sleep_mode, ser_clock_out} <= a[1:0] ^ b[1:0];
  endtask
  // pad level seen at the sampling edge is taken half a cycle before it
  task automatic cyc;
    @(negedge mclk);
    p = pin_in;
    @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic check_std;
    logic [7:0] de, dv, pu;
    de = direction_reg;
    dv = port_out_reg;
    pu = port_out_reg & ~direction_reg;
    if (timer1_compare_b_en) dv[3] = timer1_compare_b_wave;
    if (reset_pin_disable_fuse) {de[7], pu[7]} = 2'h1;
    if (clock_source == `PBAF_CLK_XTAL || clock_source == `PBAF_CLK_EXT) {de[4], pu[4]} = 2'h0;
    if (clock_source == `PBAF_CLK_XTAL) {de[5], pu[5]} = 2'h0;
    chk8(pad_drive_en, de, 8'hf8);
    chk8(pad_drive_val & de, dv & de, 8'hf8);
    chk8(pad_pullup_en, pu, 8'hf8);
    chk1(ext_reset_n, !reset_pin_disable_fuse || p[7]);
    chk1(external_irq_zero, general_irq_mask_reg[6] && p[6]);
    chk1(counter0_ext_clock_in, &counter0_control_reg[2:1] && p[6]);
    chk1(oscillator_input_pin, clock_source == `PBAF_CLK_EXT && p[4]);
    if (reset_pin_disable_fuse) chk1(digital_in[7], 1'b0);
  endtask
  task automatic two(input logic [7:0] po, input logic st, sh, input logic [7:0] e);
    @(posedge mclk);
    {port_out_reg, ser_start_detect, ser_shift_msb} <= {po, st, sh};
    cyc();
    chk8(pad_drive_en, e, 8'h05);
    chk8(pad_drive_val & pad_drive_en, 8'h00, 8'h05);
    chk8(pad_pullup_en, 8'h00, 8'h05);
  endtask
  // settle, then move pin n from outside and from its port bit, compare b wave and serial data out at once
  task automatic trig(input int n, eh, el);
    repeat (4) @(negedge mclk);
    @(posedge mclk);
    ext_val[n] <= ~ext_val[n];
    port_out_reg[n] <= ~port_out_reg[n];
    {timer1_compare_b_wave, ser_data_out} <= ~{timer1_compare_b_wave, ser_data_out};
    {hi, lo} = '0;
    repeat (6) begin
      @(negedge mclk);
      hi += pin_change_irq_high;
      lo += pin_change_irq_low;
    end
    chk8(hi, 8'(eh), 8'hff);
    chk8(lo, 8'(el), 8'hff);
  endtask
  initial begin
    #100000;
    failures++;
    finish_test();
  end
  initial begin
    resetn = 1'b0;
    quiet();
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    repeat (300) begin
      @(posedge mclk);
      rnd_inputs();
      cyc();
      check_std();
    end
    @(posedge mclk);
    quiet();
    ser_wire_mode <= `PBAF_SER_TWO;
    direction_reg <= 8'h05;
    two(8'h04, 1'b0, 1'b1, 8'h01);
    two(8'h05, 1'b1, 1'b0, 8'h05);
    two(8'h05, 1'b0, 1'b1, 8'h00);
    @(posedge mclk);
    quiet();
    ser_wire_mode <= `PBAF_SER_THREE;
    direction_reg <= 8'h06;
    {ser_data_out, ser_clock_out, timer1_compare_a_en} <= 3'h7;
    cyc();
    chk8(pad_drive_en, 8'h06, 8'h06);
    chk8(pad_drive_val, 8'h06, 8'h06);
    @(posedge mclk);
    {direction_reg, port_out_reg} <= {8'h00, 8'h02};
    cyc();
    chk8(pad_pullup_en, 8'h02, 8'h02);
    chk8(pad_drive_en, 8'h00, 8'h06);
    @(posedge mclk);
    {spi_program_en, direction_reg} <= {1'b1, 8'h04};
    cyc();
    chk8(pad_drive_en, 8'h00, 8'h04);
    @(posedge mclk);
    quiet();
    direction_reg <= 8'h0e;
    {timer1_compare_a_en, timer1_compare_a_wave, timer1_compare_b_en,
     timer1_compare_b_wave} <= 4'hf;
    cyc();
    chk8(pad_drive_en, 8'h0e, 8'h0e);
    chk8(pad_drive_val, 8'h0a, 8'h0e);
    @(posedge mclk);
    direction_reg <= 8'h00;
    cyc();
    chk8(pad_drive_en, 8'h00, 8'h0e);
    @(posedge mclk); quiet(); trig(3, 0, 1);
    @(posedge mclk); quiet(); global_irq_en <= 1'b0; trig(3, 0, 0);
    @(posedge mclk); quiet(); direction_reg <= 8'h08; trig(3, 0, 1);
    @(posedge mclk); quiet(); {direction_reg, timer1_compare_b_en} <= 9'h11; trig(3, 0, 0);
    @(posedge mclk); quiet(); reset_pin_disable_fuse <= 1'b1; trig(7, 0, 0);
    @(posedge mclk); quiet(); trig(7, 1, 0);
    @(posedge mclk); quiet(); general_irq_mask_reg <= 8'h40; trig(6, 0, 0);
    @(posedge mclk); quiet(); counter0_control_reg <= 8'h06; trig(6, 0, 0);
    @(posedge mclk); quiet(); clock_source <= `PBAF_CLK_XTAL; trig(5, 0, 0);
    @(posedge mclk); quiet(); clock_source <= `PBAF_CLK_XTAL; trig(4, 0, 0);
    @(posedge mclk); quiet(); ser_wire_mode <= `PBAF_SER_TWO; trig(2, 0, 0);
    @(posedge mclk); quiet(); {ser_wire_mode, direction_reg} <= 10'h102; trig(1, 0, 0);
    @(posedge mclk);
    quiet();
    {sleep_mode, pin_change_group_low, ext_val} <= {2'h2, 8'h08};
    cyc();
    chk1(digital_in[3], 1'b0);
    @(posedge mclk);
    pin_change_group_low <= 1'b1;
    cyc();
    chk1(digital_in[3], 1'b1);
    finish_test();
  end
endmodule
